// file: inc/e1_rx_cas_pkg.sv
// Constants and helpers for the receive signaling control block
package e1_rx_cas_pkg;

  localparam int SLOT_COUNT = 32;
  localparam int SLOT_BITS = 5;
  localparam int ADDR_BITS = 16;
  localparam int DATA_BITS = 8;
  localparam int ABCD_BITS = 4;
  localparam int PCM_WORD_BITS = SLOT_BITS + DATA_BITS;
  localparam int PCM_FIFO_DEPTH = 32;

  // Register bases, one byte register per timeslot
  localparam logic [15:0] CONTROL_BASE = 16'h03a0;
  localparam logic [15:0] SUBSTITUTE_BASE = 16'h03c0;
  localparam logic [15:0] ARRAY_BASE = 16'h0500;

  // Reset values
  localparam logic [7:0] CONTROL_RESET = 8'h00;
  localparam logic [7:0] SUBSTITUTE_RESET = 8'h00;
  localparam logic [3:0] ARRAY_RESET = 4'h0;
  localparam logic [7:0] READ_IDLE = 8'h00;

  // Control register fields
  localparam int SUB_ENABLE_BIT = 6;
  localparam int OH_ENABLE_BIT = 5;
  localparam int DEBOUNCE_BIT = 4;
  localparam int SUB_FORMAT_LSB = 2;
  localparam int EXTRACT_FORMAT_LSB = 0;

  // Substitute register fields
  localparam int SIXTEEN_A_BIT = 0;
  localparam int SIXTEEN_B_BIT = 1;
  localparam int SIXTEEN_C_BIT = 2;
  localparam int SIXTEEN_D_BIT = 3;
  localparam int FOUR_A_BIT = 4;
  localparam int FOUR_B_BIT = 5;
  localparam int TWO_A_BIT = 6;

  // ABCD nibble layout: A in bit 3 down to D in bit 0
  localparam int NIB_A = 3;
  localparam int NIB_B = 2;
  localparam int NIB_C = 1;
  localparam int NIB_D = 0;
  localparam logic [3:0] ALL_ONES_ABCD = 4'hf;
  localparam logic [3:0] MASK_ABCD = 4'hf;
  localparam logic [3:0] MASK_AB = 4'hc;
  localparam logic [3:0] MASK_A = 4'h8;
  localparam logic [3:0] MASK_NONE = 4'h0;

  typedef enum logic [1:0] {
    FMT_OFF_OR_ONES,
    FMT_SIXTEEN,
    FMT_FOUR,
    FMT_TWO
  } sig_format_t;

  // True when addr falls in the 32-entry window at base
  function automatic logic slot_hit(input logic [15:0] addr, input logic [15:0] base);
    slot_hit = (addr[15:5] == base[15:5]);
  endfunction : slot_hit

  // Bits kept by an extraction format
  function automatic logic [3:0] extract_mask(input sig_format_t fmt);
    unique case (fmt)
      FMT_OFF_OR_ONES: extract_mask = MASK_NONE;
      FMT_SIXTEEN: extract_mask = MASK_ABCD;
      FMT_FOUR: extract_mask = MASK_AB;
      FMT_TWO: extract_mask = MASK_A;
    endcase
  endfunction : extract_mask

endpackage : e1_rx_cas_pkg

// file: src/pcm_fifo.sv
// Synchronous FIFO with valid and ready on both sides
`timescale 1ns/100ps
`default_nettype none
module pcm_fifo #(
  parameter int WIDTH = 13,
  parameter int DEPTH = 32
) (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData
);
  localparam int PTR_BITS = $clog2(DEPTH);
  localparam logic [PTR_BITS:0] DEPTH_COUNT = (PTR_BITS + 1)'(DEPTH);
  localparam logic [PTR_BITS:0] ZERO_COUNT = '0;

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PTR_BITS-1:0] wrPtr_ff;
  logic [PTR_BITS-1:0] rdPtr_ff;
  logic [PTR_BITS:0] count_ff;
  logic [PTR_BITS:0] nxt_count;
  logic full_ff;
  logic empty_ff;
  logic doPush;
  logic doPop;

  assign doPush = inValid && !full_ff;
  assign doPop = outReady && !empty_ff;
  assign outValid = !empty_ff;
  assign outData = mem[rdPtr_ff];

  always_comb begin
    nxt_count = count_ff;
    if (doPush && !doPop) begin
      nxt_count = count_ff + 1'b1;
    end else if (doPop && !doPush) begin
      nxt_count = count_ff - 1'b1;
    end
  end

  // Storage
  always_ff @(posedge clk_sys) begin
    if (doPush) begin
      mem[wrPtr_ff] <= inData;
    end
  end

  // Pointers and level flags
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      wrPtr_ff <= '0;
      rdPtr_ff <= '0;
      count_ff <= '0;
      full_ff <= 1'b0;
      empty_ff <= 1'b1;
      inReady <= 1'b1;
    end else begin
      if (doPush) begin
        wrPtr_ff <= wrPtr_ff + 1'b1;
      end
      if (doPop) begin
        rdPtr_ff <= rdPtr_ff + 1'b1;
      end
      count_ff <= nxt_count;
      full_ff <= (nxt_count == DEPTH_COUNT);
      inReady <= (nxt_count != DEPTH_COUNT);
      empty_ff <= (nxt_count == ZERO_COUNT);
    end
  end
endmodule : pcm_fifo
`default_nettype wire

// file: src/e1_rx_cas_signaling_control.sv
// Receive per-timeslot signaling extraction, debounce and substitution
`timescale 1ns/100ps
`default_nettype none
// Function
// - Substitution enable replaces ABCD with substitute values
// - Substitution touches PCM output only
// - Overhead enable sends array entries to overhead
// - Debounce updates after two equal superframes
// - Debounce ignores values differing between superframes
// - Without debounce, update on every change
// - Format 00 forces signaling bits to one
// - Sixteen-code uses substitute bits 0 to 3
// - Four-code uses substitute bits 4 and 5
// - Two-code uses substitute bit 6 for A
// - Extraction 00 extracts nothing
// - Extraction 01 extracts A, B, C, D
// - Extraction 10 extracts A and B
// - Extraction 11 extracts only A
// - Read-only array per slot, ABCD bits 3..0
// - Substitute registers indexed by timeslot
// - Array meaningful only in CAS mode
module e1_rx_cas_signaling_control
  import e1_rx_cas_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_b,
  // Register port
  input wire logic [ADDR_BITS-1:0] regAddr,
  input wire logic [DATA_BITS-1:0] regWrData,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [DATA_BITS-1:0] regRdData,
  // Framer status
  input wire logic casMode,
  // Received signaling, one sample per slot per superframe
  input wire logic sigInValid,
  input wire logic [SLOT_BITS-1:0] sigInSlot,
  input wire logic [ABCD_BITS-1:0] sigInAbcd,
  // Received PCM octets, low nibble holds ABCD when pcmInSig is set
  input wire logic pcmInValid,
  output logic pcmInReady,
  input wire logic [SLOT_BITS-1:0] pcmInSlot,
  input wire logic [DATA_BITS-1:0] pcmInOctet,
  input wire logic pcmInSig,
  // Receive PCM serial output
  output logic rxPcmSerialOutValid,
  input wire logic rxPcmSerialOutReady,
  output logic [SLOT_BITS-1:0] rxPcmSerialOutSlot,
  output logic [DATA_BITS-1:0] rxPcmSerialOutOctet,
  // Receive signaling bus output
  output logic rxSignalingBusOutValid,
  output logic [SLOT_BITS-1:0] rxSignalingBusOutSlot,
  output logic [ABCD_BITS-1:0] rxSignalingBusOutAbcd,
  // Receive overhead output
  output logic rxOverheadOutValid,
  output logic [SLOT_BITS-1:0] rxOverheadOutSlot,
  output logic [ABCD_BITS-1:0] rxOverheadOutAbcd
);

  logic [DATA_BITS-1:0] rxSigSlotControl_ff [SLOT_COUNT];
  logic [DATA_BITS-1:0] rxSigSlotSubstitute_ff [SLOT_COUNT];
  logic [ABCD_BITS-1:0] rxSigSlotArray_ff [SLOT_COUNT];
  logic [ABCD_BITS-1:0] candidate_ff [SLOT_COUNT];
  logic [DATA_BITS-1:0] regRdData_ff;
  logic [DATA_BITS-1:0] nxt_regRdData;

  logic ctlHit;
  logic subHit;
  logic arrHit;
  logic [SLOT_BITS-1:0] regSlot;

  logic [DATA_BITS-1:0] sigCtl;
  sig_format_t extractionFormat;
  logic [ABCD_BITS-1:0] extractMask;
  logic [ABCD_BITS-1:0] extracted;
  logic sigDebounceEnable;
  logic overheadOutputEnable;
  logic sigAccept;
  logic arrayUpdate;
  logic sampleRepeats;
  logic sampleDiffers;

  logic [DATA_BITS-1:0] pcmCtl;
  logic [DATA_BITS-1:0] pcmSub;
  sig_format_t substitutionFormat;
  logic sigSubstituteEnable;
  logic [ABCD_BITS-1:0] rxNibble;
  logic [ABCD_BITS-1:0] subNibble;
  logic [DATA_BITS-1:0] pcmOctetOut;
  logic substituteNow;

  logic fifoOutValid;
  logic fifoOutReady;
  logic [PCM_WORD_BITS-1:0] fifoOutData;
  logic pcmOutValid_ff;
  logic [SLOT_BITS-1:0] pcmOutSlot_ff;
  logic [DATA_BITS-1:0] pcmOutOctet_ff;

  logic busValid_ff;
  logic [SLOT_BITS-1:0] busSlot_ff;
  logic [ABCD_BITS-1:0] busAbcd_ff;
  logic ohValid_ff;
  logic [SLOT_BITS-1:0] ohSlot_ff;
  logic [ABCD_BITS-1:0] ohAbcd_ff;
  logic ohUpdate;

  // Two-bit format field of a control byte
  function automatic sig_format_t ctl_format(input logic [DATA_BITS-1:0] ctl, input int lsb);
    ctl_format = sig_format_t'(ctl[lsb +: 2]);
  endfunction : ctl_format

  // Address decode
  assign ctlHit = slot_hit(regAddr, CONTROL_BASE);
  assign subHit = slot_hit(regAddr, SUBSTITUTE_BASE);
  assign arrHit = slot_hit(regAddr, ARRAY_BASE);
  assign regSlot = regAddr[SLOT_BITS-1:0];

  // Control registers
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      for (int i = 0; i < SLOT_COUNT; i++) begin
        rxSigSlotControl_ff[i] <= CONTROL_RESET;
      end
    end else if (regWrite && ctlHit) begin
      rxSigSlotControl_ff[regSlot] <= regWrData;
    end
  end

  // Substitute registers
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      for (int i = 0; i < SLOT_COUNT; i++) begin
        rxSigSlotSubstitute_ff[i] <= SUBSTITUTE_RESET;
      end
    end else if (regWrite && subHit) begin
      rxSigSlotSubstitute_ff[regSlot] <= regWrData;
    end
  end

  // Read mux, idle when no read strobe
  always_comb begin
    nxt_regRdData = READ_IDLE;
    if (regRead) begin
      if (ctlHit) begin
        nxt_regRdData = rxSigSlotControl_ff[regSlot];
      end else if (subHit) begin
        nxt_regRdData = rxSigSlotSubstitute_ff[regSlot];
      end else if (arrHit) begin
        nxt_regRdData = {4'h0, rxSigSlotArray_ff[regSlot]};
      end
    end
  end

  // Read data, one cycle after the strobe
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      regRdData_ff <= READ_IDLE;
    end else begin
      regRdData_ff <= nxt_regRdData;
    end
  end
  assign regRdData = regRdData_ff;

  // Extraction side, received values only
  assign sigCtl = rxSigSlotControl_ff[sigInSlot];
  assign extractionFormat = ctl_format(sigCtl, EXTRACT_FORMAT_LSB);
  assign extractMask = extract_mask(extractionFormat);
  assign extracted = sigInAbcd & extractMask;
  assign sigDebounceEnable = sigCtl[DEBOUNCE_BIT];
  assign overheadOutputEnable = sigCtl[OH_ENABLE_BIT];
  assign sigAccept = sigInValid && casMode && (extractionFormat != FMT_OFF_OR_ONES);

  // Debounce compares against last sample and current entry
  assign sampleRepeats = (extracted == candidate_ff[sigInSlot]);
  assign sampleDiffers = (extracted != rxSigSlotArray_ff[sigInSlot]);

  always_comb begin
    arrayUpdate = 1'b0;
    if (sigAccept) begin
      if (sigDebounceEnable) begin
        arrayUpdate = sampleRepeats && sampleDiffers;
      end else begin
        arrayUpdate = sampleDiffers;
      end
    end
  end

  // Last superframe sample for debounce
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      for (int i = 0; i < SLOT_COUNT; i++) begin
        candidate_ff[i] <= ARRAY_RESET;
      end
    end else if (sigAccept) begin
      candidate_ff[sigInSlot] <= extracted;
    end
  end

  // Signaling array
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      for (int i = 0; i < SLOT_COUNT; i++) begin
        rxSigSlotArray_ff[i] <= ARRAY_RESET;
      end
    end else if (arrayUpdate) begin
      rxSigSlotArray_ff[sigInSlot] <= extracted;
    end
  end

  // Signaling bus strobe, one per array change
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      busValid_ff <= 1'b0;
    end else begin
      busValid_ff <= arrayUpdate;
    end
  end

  // Signaling bus payload, held until the next change
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      busSlot_ff <= '0;
      busAbcd_ff <= ARRAY_RESET;
    end else if (arrayUpdate) begin
      busSlot_ff <= sigInSlot;
      busAbcd_ff <= extracted;
    end
  end

  // Overhead strobe, only for slots with overhead enabled
  assign ohUpdate = arrayUpdate && overheadOutputEnable;

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      ohValid_ff <= 1'b0;
    end else begin
      ohValid_ff <= ohUpdate;
    end
  end

  // Overhead payload, ABCD cleared and slot kept while the addressed slot has overhead off
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      ohSlot_ff <= '0;
      ohAbcd_ff <= ARRAY_RESET;
    end else if (ohUpdate) begin
      ohSlot_ff <= sigInSlot;
      ohAbcd_ff <= extracted;
    end else if (!overheadOutputEnable) begin
      ohAbcd_ff <= ARRAY_RESET;
    end
  end

  assign rxSignalingBusOutValid = busValid_ff;
  assign rxSignalingBusOutSlot = busSlot_ff;
  assign rxSignalingBusOutAbcd = busAbcd_ff;
  assign rxOverheadOutValid = ohValid_ff;
  assign rxOverheadOutSlot = ohSlot_ff;
  assign rxOverheadOutAbcd = ohAbcd_ff;

  // Substitution in the PCM path
  assign pcmCtl = rxSigSlotControl_ff[pcmInSlot];
  assign pcmSub = rxSigSlotSubstitute_ff[pcmInSlot];
  assign substitutionFormat = ctl_format(pcmCtl, SUB_FORMAT_LSB);
  assign sigSubstituteEnable = pcmCtl[SUB_ENABLE_BIT];
  assign rxNibble = pcmInOctet[ABCD_BITS-1:0];

  always_comb begin
    subNibble = rxNibble;
    unique case (substitutionFormat)
      FMT_OFF_OR_ONES: begin
        subNibble = ALL_ONES_ABCD;
      end
      FMT_SIXTEEN: begin
        subNibble[NIB_A] = pcmSub[SIXTEEN_A_BIT];
        subNibble[NIB_B] = pcmSub[SIXTEEN_B_BIT];
        subNibble[NIB_C] = pcmSub[SIXTEEN_C_BIT];
        subNibble[NIB_D] = pcmSub[SIXTEEN_D_BIT];
      end
      FMT_FOUR: begin
        subNibble[NIB_A] = pcmSub[FOUR_A_BIT];
        subNibble[NIB_B] = pcmSub[FOUR_B_BIT];
      end
      FMT_TWO: begin
        subNibble[NIB_A] = pcmSub[TWO_A_BIT];
      end
    endcase
  end

  // Only octets that carry signaling are candidates
  assign substituteNow = pcmInSig && sigSubstituteEnable;

  always_comb begin
    pcmOctetOut = pcmInOctet;
    if (substituteNow) begin
      pcmOctetOut = {pcmInOctet[DATA_BITS-1:ABCD_BITS], subNibble};
    end
  end

  pcm_fifo #(
    .WIDTH(PCM_WORD_BITS),
    .DEPTH(PCM_FIFO_DEPTH)
  ) u_pcm_fifo (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .inValid(pcmInValid),
    .inReady(pcmInReady),
    .inData({pcmInSlot, pcmOctetOut}),
    .outValid(fifoOutValid),
    .outReady(fifoOutReady),
    .outData(fifoOutData)
  );

  // Output register stage of the PCM stream
  assign fifoOutReady = !pcmOutValid_ff || rxPcmSerialOutReady;

  // Output word present, held through a stall
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      pcmOutValid_ff <= 1'b0;
    end else if (fifoOutReady) begin
      pcmOutValid_ff <= fifoOutValid;
    end
  end

  // Output word contents
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      pcmOutSlot_ff <= '0;
      pcmOutOctet_ff <= '0;
    end else if (fifoOutReady && fifoOutValid) begin
      pcmOutSlot_ff <= fifoOutData[PCM_WORD_BITS-1:DATA_BITS];
      pcmOutOctet_ff <= fifoOutData[DATA_BITS-1:0];
    end
  end

  assign rxPcmSerialOutValid = pcmOutValid_ff;
  assign rxPcmSerialOutSlot = pcmOutSlot_ff;
  assign rxPcmSerialOutOctet = pcmOutOctet_ff;

endmodule : e1_rx_cas_signaling_control
`default_nettype wire

// file: verification/e1_rx_cas_properties.sv
// Port checker for the receive signaling control block
`timescale 1ns/100ps
`default_nettype none
module e1_rx_cas_properties
  import e1_rx_cas_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic [ADDR_BITS-1:0] regAddr,
  input wire logic [DATA_BITS-1:0] regWrData,
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic [DATA_BITS-1:0] regRdData,
  input wire logic casMode,
  input wire logic sigInValid,
  input wire logic [SLOT_BITS-1:0] sigInSlot,
  input wire logic [ABCD_BITS-1:0] sigInAbcd,
  input wire logic pcmInValid,
  input wire logic pcmInReady,
  input wire logic [SLOT_BITS-1:0] pcmInSlot,
  input wire logic [DATA_BITS-1:0] pcmInOctet,
  input wire logic pcmInSig,
  input wire logic rxPcmSerialOutValid,
  input wire logic rxPcmSerialOutReady,
  input wire logic [SLOT_BITS-1:0] rxPcmSerialOutSlot,
  input wire logic [DATA_BITS-1:0] rxPcmSerialOutOctet,
  input wire logic rxSignalingBusOutValid,
  input wire logic [SLOT_BITS-1:0] rxSignalingBusOutSlot,
  input wire logic [ABCD_BITS-1:0] rxSignalingBusOutAbcd,
  input wire logic rxOverheadOutValid,
  input wire logic [SLOT_BITS-1:0] rxOverheadOutSlot,
  input wire logic [ABCD_BITS-1:0] rxOverheadOutAbcd
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  logic [6:0] inFlight_ff;
  // Words taken but not yet delivered
  always_ff @(posedge clk_sys) begin
    if (!rst_b) inFlight_ff <= 7'h00;
    else inFlight_ff <= inFlight_ff + 7'(pcmInValid && pcmInReady) - 7'(rxPcmSerialOutValid && rxPcmSerialOutReady);
  end
  sequence pcmStall;
    rxPcmSerialOutValid && !rxPcmSerialOutReady;
  endsequence
  sequence pcmHeld;
    rxPcmSerialOutValid && $stable(rxPcmSerialOutOctet) && $stable(rxPcmSerialOutSlot);
  endsequence
  AST_RD_IDLE:
    assert property (!regRead |=> regRdData == READ_IDLE) else $error("read data not idle");
  AST_ARRAY_RSVD:
    assert property (regRead && regAddr[15:5] == ARRAY_BASE[15:5] |=> regRdData[7:4] == 4'h0)
      else $error("array upper bits set");
  AST_BUS_CAUSE:
    assert property (rxSignalingBusOutValid |-> $past(sigInValid && casMode)) else $error("bus pulse without sample");
  AST_BUS_SLOT:
    assert property (rxSignalingBusOutValid |-> rxSignalingBusOutSlot == $past(sigInSlot)) else $error("bus slot");
  AST_BUS_BITS:
    assert property (rxSignalingBusOutValid |-> (rxSignalingBusOutAbcd & ~$past(sigInAbcd)) == 4'h0)
      else $error("bus bit not received");
  AST_OH_MIRROR:
    assert property (rxOverheadOutValid |-> rxSignalingBusOutValid && rxOverheadOutAbcd == rxSignalingBusOutAbcd
      && rxOverheadOutSlot == rxSignalingBusOutSlot) else $error("overhead differs from array");
  AST_PCM_HOLD:
    assert property (pcmStall |=> pcmHeld) else $error("pcm word dropped in stall");
  AST_PCM_FULL:
    assert property (!pcmInReady |-> inFlight_ff >= 7'h20) else $error("refused before full");
  AST_PCM_LAT:
    assert property (pcmInValid && pcmInReady && inFlight_ff == 7'h00 |-> ##[1:3] rxPcmSerialOutValid)
      else $error("pcm word late");
endmodule : e1_rx_cas_properties
bind e1_rx_cas_signaling_control e1_rx_cas_properties e1_rx_cas_properties_inst (.*);
`default_nettype wire

// file: verification/pcm_sink_model.sv
// Backplane sink taking receive PCM words
`timescale 1ns/100ps
`default_nettype none
module pcm_sink_model (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic hold,
  output logic rxPcmSerialOutReady
);
  // Ready at random, or stopped while hold is high
  always_ff @(posedge clk_sys) begin
    if (!rst_b) rxPcmSerialOutReady <= 1'b0;
    else rxPcmSerialOutReady <= !hold && ($urandom % 3 != 0);
  end
endmodule : pcm_sink_model
`default_nettype wire

// file: verification/e1_rx_cas_signaling_control_tb.sv
// Bench for the receive signaling control block
`timescale 1ns/100ps
`default_nettype none
module e1_rx_cas_signaling_control_tb
  import e1_rx_cas_pkg::*;
;
  logic clk_sys = 1'b0, rst_b = 1'b0, regWrite = 1'b0, regRead = 1'b0, casMode = 1'b1, hold = 1'b0;
  logic sigInValid = 1'b0, pcmInValid = 1'b0, pcmInSig = 1'b0, rdPend = 1'b0;
  logic [15:0] regAddr = 16'h0000;
  logic [7:0] regWrData = 8'h00, pcmInOctet = 8'h00;
  logic [4:0] sigInSlot = 5'h00, pcmInSlot = 5'h00;
  logic [3:0] sigInAbcd = 4'h0;
  logic pcmInReady, rxPcmSerialOutValid, rxPcmSerialOutReady, rxSignalingBusOutValid, rxOverheadOutValid;
  logic [7:0] regRdData, rxPcmSerialOutOctet;
  logic [4:0] rxPcmSerialOutSlot, rxSignalingBusOutSlot, rxOverheadOutSlot;
  logic [3:0] rxSignalingBusOutAbcd, rxOverheadOutAbcd;
  logic [7:0] ctl [32], sub [32];
  logic [3:0] arr [32], cand [32];
  logic [12:0] rdQ [$], sigQ [$], pcmQ [$];
  int miscompares = 0, n_compared = 0, cyc = 0;
  e1_rx_cas_signaling_control e1_rx_cas_signaling_control_inst (.*);
  pcm_sink_model pcm_sink_model_inst (.*);
  initial forever #12.5 clk_sys = ~clk_sys;
  task automatic close_out();
    $display("compared %0d miscompares %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : close_out
  task automatic cmp(logic [12:0] got, logic [12:0] want, string what);
    n_compared++;
    if (got !== want) begin
      miscompares++;
      $display("unexpected at %0t: %s got %h want %h", $time, what, got, want);
    end
  endtask : cmp
  task automatic check_read(logic [12:0] got, logic [12:0] want);
    cmp(got, want, "read");
  endtask : check_read
  task automatic check_sig(logic [12:0] got, logic [12:0] want);
    cmp(got, want, "signaling");
  endtask : check_sig
  task automatic check_pcm(logic [12:0] got, logic [12:0] want);
    cmp(got, want, "pcm");
  endtask : check_pcm
  function automatic logic [12:0] oldest(ref logic [12:0] q [$]);
    return q.size() != 0 ? q.pop_front() : 'x;
  endfunction : oldest
  task automatic wr(logic [15:0] a, logic [7:0] d);
    if (a[15:5] == CONTROL_BASE[15:5]) ctl[a[4:0]] = d;
    if (a[15:5] == SUBSTITUTE_BASE[15:5]) sub[a[4:0]] = d;
    regAddr <= a;
    regWrData <= d;
    regWrite <= 1'b1;
    @(posedge clk_sys);
    regWrite <= 1'b0;
    @(posedge clk_sys);
  endtask : wr
  task automatic rd(logic [15:0] a);
    logic [7:0] e;
    e = 8'h00;
    if (a[15:5] == CONTROL_BASE[15:5]) e = ctl[a[4:0]];
    if (a[15:5] == SUBSTITUTE_BASE[15:5]) e = sub[a[4:0]];
    if (a[15:5] == ARRAY_BASE[15:5]) e = {4'h0, arr[a[4:0]]};
    rdQ.push_back(13'(e));
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge clk_sys);
    regRead <= 1'b0;
    @(posedge clk_sys);
  endtask : rd
  task automatic samp(logic [4:0] s, logic [3:0] v, logic c);
    logic [1:0] f;
    logic [3:0] e;
    f = ctl[s][1:0];
    e = v & (f == 2'd1 ? 4'hf : f == 2'd2 ? 4'hc : f == 2'd3 ? 4'h8 : 4'h0);
    if (c && f != 2'd0 && e != arr[s] && (!ctl[s][4] || e == cand[s])) begin
      arr[s] = e;
      sigQ.push_back(13'({ctl[s][5], s, e}));
    end
    if (c && f != 2'd0) cand[s] = e;
    casMode <= c;
    sigInSlot <= s;
    sigInAbcd <= v;
    sigInValid <= 1'b1;
    @(posedge clk_sys);
    sigInValid <= 1'b0;
    @(posedge clk_sys);
  endtask : samp
  task automatic pcm(logic [4:0] s, logic [7:0] o, logic g, output bit ok);
    logic [7:0] e;
    int n;
    e = o;
    n = 0;
    if (g && ctl[s][6]) case (ctl[s][3:2])
      2'd0: e[3:0] = 4'hf;
      2'd1: e[3:0] = {sub[s][0], sub[s][1], sub[s][2], sub[s][3]};
      2'd2: e[3:2] = {sub[s][4], sub[s][5]};
      default: e[3] = sub[s][6];
    endcase
    pcmInSlot <= s;
    pcmInOctet <= o;
    pcmInSig <= g;
    pcmInValid <= 1'b1;
    do begin
      @(posedge clk_sys);
      n++;
    end while (!pcmInReady && n < 8);
    ok = pcmInReady;
    if (ok) pcmQ.push_back(13'({s, e}));
  endtask : pcm
  task automatic settle();
    int n;
    n = 0;
    pcmInValid <= 1'b0;
    while ((pcmQ.size() != 0 || sigQ.size() != 0) && n++ < 500) @(posedge clk_sys);
    @(posedge clk_sys);
  endtask : settle
  always @(posedge clk_sys) begin
    logic [12:0] sigWant;
    cyc++;
    if (rdPend) check_read(13'(regRdData), oldest(rdQ));
    rdPend <= regRead;
    if (rxSignalingBusOutValid) begin
      sigWant = oldest(sigQ);
      check_sig(13'({rxOverheadOutValid, rxSignalingBusOutSlot, rxSignalingBusOutAbcd}), sigWant);
      if (rxOverheadOutValid) check_sig(13'({1'b1, rxOverheadOutSlot, rxOverheadOutAbcd}), sigWant);
    end
    if (rxOverheadOutValid && !rxSignalingBusOutValid) check_sig(13'h0001, 13'h0000);
    if (rxPcmSerialOutValid && rxPcmSerialOutReady) begin
      check_pcm(13'({rxPcmSerialOutSlot, rxPcmSerialOutOctet}), oldest(pcmQ));
    end
    if (cyc > 30000) begin
      miscompares++;
      $display("unexpected at %0t: timeout", $time);
      close_out();
    end
  end
  initial begin
    bit ok;
    int n;
    void'($urandom(83627));
    foreach (ctl[i]) begin
      ctl[i] = 8'h00;
      sub[i] = 8'h00;
      arr[i] = 4'h0;
      cand[i] = 4'h0;
    end
    repeat (20) @(posedge clk_sys);
    rst_b <= 1'b1;
    @(posedge clk_sys);
    for (int p = 0; p < 2; p++) begin
      for (int i = 0; i < 32; i++) begin
        rd(CONTROL_BASE + 16'(i));
        rd(SUBSTITUTE_BASE + 16'(i));
        rd(ARRAY_BASE + 16'(i));
        if (p == 0) begin
          wr(ARRAY_BASE + 16'(i), 8'hff);
          wr(SUBSTITUTE_BASE + 16'(i), 8'($urandom) & 8'h7f);
          wr(CONTROL_BASE + 16'(i), 8'((i % 16) | ((i % 3) << 5)));
        end
      end
    end
    wr(16'h0520, 8'h5a);
    rd(16'h0520);
    rd(16'h03e0);
    repeat (300) samp(5'($urandom % 24), 4'($urandom), ($urandom % 8) != 0);
    wr(CONTROL_BASE + 16'd30, 8'h31);
    wr(CONTROL_BASE + 16'd31, 8'h12);
    for (int i = 0; i < 60; i++) samp(5'(30 + i % 2), 4'($urandom % 3) << 2, 1'b1);
    for (int i = 0; i < 32; i++) rd(ARRAY_BASE + 16'(i));
    repeat (200) pcm(5'($urandom), 8'($urandom), 1'($urandom), ok);
    settle();
    hold <= 1'b1;
    n = 0;
    do begin
      pcm(5'($urandom), 8'($urandom), 1'b1, ok);
      n += int'(ok);
    end while (ok && n < 40);
    pcmInValid <= 1'b0;
    cmp(13'(n), 13'h0021, "fill depth");
    @(posedge clk_sys);
    hold <= 1'b0;
    settle();
    cmp(13'(rdQ.size() + sigQ.size() + pcmQ.size()), 13'h0000, "leftover");
    close_out();
  end
endmodule : e1_rx_cas_signaling_control_tb
`default_nettype wire
